// ### logic/ctwm_pkg.sv
// Shared constants for the cycle time watchdog monitor
package ctwm_pkg;
   // Timing base
   localparam int CLK_NS = 50;
   localparam int TICK_NS = 100000;
   localparam int TICK_CLKS = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int TICKS_PER_MS = 10;
   localparam int WATCH_DEFAULT_MS = 1000;
   localparam int WATCH_STEP_MS = 10;
   localparam int SVC_LIMIT_MS = 2000;
   localparam logic [31:0] WATCH_DEFAULT_TICKS = 32'(WATCH_DEFAULT_MS * TICKS_PER_MS);
   localparam logic [31:0] WATCH_STEP_TICKS = 32'(WATCH_STEP_MS * TICKS_PER_MS);
   localparam logic [31:0] SVC_LIMIT_TICKS = 32'(SVC_LIMIT_MS * TICKS_PER_MS);
   // Watch setup word layout
   localparam int SETUP_SEL_BIT = 15;
   localparam logic [14:0] SETUP_CODE_MIN = 15'h0001;
   localparam logic [14:0] SETUP_CODE_MAX = 15'h0FA0;
   localparam logic [15:0] SETUP_RESET = 16'h0001;
   // Auxiliary word addresses
   localparam logic [15:0] ADDR_WATCH_SETUP = 16'h00D1;
   localparam logic [15:0] ADDR_PEAK_LOW = 16'h0106;
   localparam logic [15:0] ADDR_PEAK_HIGH = 16'h0107;
   localparam logic [15:0] ADDR_LATEST_LOW = 16'h0108;
   localparam logic [15:0] ADDR_LATEST_HIGH = 16'h0109;
   localparam logic [15:0] ADDR_SVC_PERIOD = 16'h010C;
   // Interrupt task numbers
   localparam logic [7:0] TASK_POWER = 8'h01;
   localparam logic [7:0] TASK_SCHED_BASE = 8'h02;
   localparam logic [7:0] TASK_IO_BASE = 8'h64;
   localparam int IO_IRQ_N = 32;
   localparam int SCHED_N = 2;
   localparam int HIST_DEPTH = 8;
   localparam int HIST_AW = 3;
   localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   // Cycle measurement phase
   typedef enum logic [1:0] {PH_IDLE, PH_PROG, PH_TAIL} ctwm_phase_t;
endpackage : ctwm_pkg

// ### logic/ctwm_hist_mem.sv
// Small history memory with registered read data
`timescale 1ns/1ps
module ctwm_hist_mem
   import ctwm_pkg::*;
#(
   parameter int W = 32,
   parameter int D = HIST_DEPTH,
   parameter int AW = HIST_AW
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data_r
);
   logic [W-1:0] mem_r [D];
   logic [W-1:0] mem_nxt [D];
   logic [W-1:0] rd_data_nxt;

   // Write port and registered read
   always_comb begin
      for (int i = 0; i < D; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      if (wr_en) begin
         mem_nxt[wr_addr] = wr_data;
      end
      rd_data_nxt = mem_r[rd_addr];
   end

   // Cleared at reset so the running mean starts from zero
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < D; i++) begin
            mem_r[i] <= '0;
         end
         rd_data_r <= '0;
      end else begin
         mem_r <= mem_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end
endmodule : ctwm_hist_mem

// ### logic/ctwm_monitor.sv
// Cycle time watchdog, cycle statistics and interrupt task dispatch
`timescale 1ns/1ps
module ctwm_monitor
   import ctwm_pkg::*;
#(
   parameter int SCHED_TICKS = 100,
   parameter int TICK_DIV = TICK_CLKS,
   parameter int IO_N = IO_IRQ_N
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic parallel_mode,
   input wire logic cycle_start,
   input wire logic prog_end,
   input wire logic cycle_end,
   input wire logic svc_start,
   input wire logic svc_end,
   input wire logic aux_wr,
   input wire logic [15:0] aux_addr,
   input wire logic [15:0] aux_wdata,
   input wire logic [IO_N-1:0] io_irq_in,
   input wire logic [IO_N-1:0] io_both_edge,
   input wire logic power_fail,
   input wire logic ext_req,
   input wire logic [7:0] ext_task,
   output logic [15:0] aux_rdata_r,
   output logic [31:0] latest_cycle_r,
   output logic [31:0] peak_cycle_r,
   output logic [31:0] avg_cycle_r,
   output logic [15:0] service_period_word_r,
   output logic cycle_overrun_flag_r,
   output logic service_overrun_flag_r,
   output logic run_enable_r,
   output logic ext_busy_r,
   output logic task_launch_r,
   output logic [7:0] task_num_r
);
   localparam logic [11:0] TICK_LAST = 12'(TICK_DIV - 1);
   localparam logic [15:0] SCHED_LAST = 16'(SCHED_TICKS - 1);

   // Watch limit in 0.1 ms ticks from the setup word
   function automatic logic [31:0] ctwm_limit(input logic [15:0] setup);
      logic [14:0] code;
      code = setup[14:0];
      if (!setup[SETUP_SEL_BIT] || code < SETUP_CODE_MIN) begin
         ctwm_limit = WATCH_DEFAULT_TICKS;
      end else begin
         if (code > SETUP_CODE_MAX) begin
            code = SETUP_CODE_MAX;
         end
         ctwm_limit = 32'(code * WATCH_STEP_TICKS);
      end
   endfunction : ctwm_limit

   // Saturating tick increment
   function automatic logic [31:0] ctwm_inc(input logic [31:0] v);
      ctwm_inc = (v == CNT_MAX) ? v : v + 32'h00000001;
   endfunction : ctwm_inc

   ////////////////////////////////////////////////////////////////////////////
   // Time base: one tick per 0.1 ms
   logic [11:0] presc_r;
   logic [11:0] presc_nxt;
   logic tick_r;
   logic tick_nxt;

   always_comb begin
      tick_nxt = (presc_r == TICK_LAST);
      presc_nxt = tick_nxt ? 12'h000 : presc_r + 12'h001;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         presc_r <= 12'h000;
         tick_r <= 1'b0;
      end else begin
         presc_r <= presc_nxt;
         tick_r <= tick_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Setup word and auxiliary word reads
   logic [15:0] setup_r;
   logic [15:0] setup_nxt;
   logic [15:0] aux_rdata_nxt;
   logic [31:0] limit_ticks;

   always_comb begin
      setup_nxt = setup_r;
      if (aux_wr && aux_addr == ADDR_WATCH_SETUP) begin
         setup_nxt = aux_wdata;
      end
      limit_ticks = ctwm_limit(setup_r);
      unique case (aux_addr)
         ADDR_WATCH_SETUP: aux_rdata_nxt = setup_r;
         ADDR_PEAK_LOW: aux_rdata_nxt = peak_cycle_r[15:0];
         ADDR_PEAK_HIGH: aux_rdata_nxt = peak_cycle_r[31:16];
         ADDR_LATEST_LOW: aux_rdata_nxt = latest_cycle_r[15:0];
         ADDR_LATEST_HIGH: aux_rdata_nxt = latest_cycle_r[31:16];
         ADDR_SVC_PERIOD: aux_rdata_nxt = service_period_word_r;
         default: aux_rdata_nxt = 16'h0000; // Unmapped words read zero
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         setup_r <= SETUP_RESET;
         aux_rdata_r <= 16'h0000;
      end else begin
         setup_r <= setup_nxt;
         aux_rdata_r <= aux_rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle measurement, watch check and statistics
   ctwm_phase_t phase_r;
   ctwm_phase_t phase_nxt;
   logic [31:0] cyc_cnt_r;
   logic [31:0] cyc_cnt_nxt;
   logic [31:0] latest_nxt;
   logic [31:0] peak_nxt;
   logic [HIST_AW-1:0] hist_ptr_r;
   logic [HIST_AW-1:0] hist_ptr_nxt;
   logic [34:0] sum_r;
   logic [34:0] sum_nxt;
   logic [31:0] avg_nxt;
   logic [31:0] hist_old;
   logic record;
   logic cyc_over;
   logic halted;

   ctwm_hist_mem #(
      .W(32),
      .D(HIST_DEPTH),
      .AW(HIST_AW)
   ) u_hist (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .wr_en(record),
      .wr_addr(hist_ptr_r),
      .wr_data(cyc_cnt_r),
      .rd_addr(hist_ptr_r),
      .rd_data_r(hist_old)
   );

   assign halted = cycle_overrun_flag_r | service_overrun_flag_r;
   // Parallel mode closes the measurement at the end of program execution
   assign record = (phase_r == PH_PROG) && (parallel_mode ? prog_end : cycle_end);
   assign cyc_over = (phase_r == PH_PROG) && (cyc_cnt_r > limit_ticks);

   always_comb begin
      phase_nxt = phase_r;
      cyc_cnt_nxt = cyc_cnt_r;
      latest_nxt = latest_cycle_r;
      peak_nxt = peak_cycle_r;
      hist_ptr_nxt = hist_ptr_r;
      sum_nxt = sum_r;
      avg_nxt = avg_cycle_r;
      if (halted || cyc_over) begin
         phase_nxt = PH_IDLE;
      end else if (cycle_start) begin
         phase_nxt = PH_PROG;
         cyc_cnt_nxt = 32'h00000000;
      end else begin
         unique case (phase_r)
            PH_IDLE: begin
               phase_nxt = PH_IDLE;
            end
            PH_PROG: begin
               if (tick_r) begin
                  cyc_cnt_nxt = ctwm_inc(cyc_cnt_r);
               end
               if (record) begin
                  phase_nxt = parallel_mode ? PH_TAIL : PH_IDLE;
               end
            end
            PH_TAIL: begin
               if (cycle_end) begin
                  phase_nxt = PH_IDLE;
               end
            end
         endcase
      end
      if (record && !halted && !cyc_over) begin
         latest_nxt = cyc_cnt_r;
         if (cyc_cnt_r > peak_cycle_r) begin
            peak_nxt = cyc_cnt_r;
         end
         // Running sum drops the oldest of the eight samples
         sum_nxt = sum_r + {3'b000, cyc_cnt_r} - {3'b000, hist_old};
         avg_nxt = sum_nxt[34:3];
         hist_ptr_nxt = hist_ptr_r + 3'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= PH_IDLE;
         cyc_cnt_r <= 32'h00000000;
         latest_cycle_r <= 32'h00000000;
         peak_cycle_r <= 32'h00000000;
         hist_ptr_r <= '0;
         sum_r <= '0;
         avg_cycle_r <= 32'h00000000;
      end else begin
         phase_r <= phase_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
         latest_cycle_r <= latest_nxt;
         peak_cycle_r <= peak_nxt;
         hist_ptr_r <= hist_ptr_nxt;
         sum_r <= sum_nxt;
         avg_cycle_r <= avg_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral servicing supervision and halt flags
   logic svc_act_r;
   logic svc_act_nxt;
   logic [31:0] svc_cnt_r;
   logic [31:0] svc_cnt_nxt;
   logic [15:0] svc_word_nxt;
   logic cyc_flag_nxt;
   logic svc_flag_nxt;
   logic svc_over;

   assign svc_over = svc_act_r && (svc_cnt_r > SVC_LIMIT_TICKS);

   always_comb begin
      svc_act_nxt = svc_act_r;
      svc_cnt_nxt = svc_cnt_r;
      svc_word_nxt = service_period_word_r;
      if (svc_start) begin
         svc_act_nxt = 1'b1;
         svc_cnt_nxt = 32'h00000000;
      end else if (svc_act_r) begin
         if (tick_r) begin
            svc_cnt_nxt = ctwm_inc(svc_cnt_r);
         end
         if (svc_end || svc_over) begin
            svc_act_nxt = 1'b0;
         end
         if (svc_end && parallel_mode) begin
            // Word saturates, the servicing limit keeps it far below the top
            svc_word_nxt = (svc_cnt_r > 32'(WORD_MAX)) ? WORD_MAX : svc_cnt_r[15:0];
         end
      end
      // Flags stay set until reset so the stop cannot be missed
      cyc_flag_nxt = cycle_overrun_flag_r | cyc_over;
      svc_flag_nxt = service_overrun_flag_r | svc_over;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         svc_act_r <= 1'b0;
         svc_cnt_r <= 32'h00000000;
         service_period_word_r <= 16'h0000;
         cycle_overrun_flag_r <= 1'b0;
         service_overrun_flag_r <= 1'b0;
         run_enable_r <= 1'b0;
      end else begin
         svc_act_r <= svc_act_nxt;
         svc_cnt_r <= svc_cnt_nxt;
         service_period_word_r <= svc_word_nxt;
         cycle_overrun_flag_r <= cyc_flag_nxt;
         service_overrun_flag_r <= svc_flag_nxt;
         run_enable_r <= ~(cyc_flag_nxt | svc_flag_nxt);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt sources and task dispatch, one launch per clock
   logic [IO_N-1:0] io_prev_r;
   logic [IO_N-1:0] io_pend_r;
   logic [IO_N-1:0] io_pend_nxt;
   logic [15:0] sched_cnt_r [SCHED_N];
   logic [15:0] sched_cnt_nxt [SCHED_N];
   logic [SCHED_N-1:0] sched_pend_r;
   logic [SCHED_N-1:0] sched_pend_nxt;
   logic pwr_prev_r;
   logic pwr_pend_r;
   logic pwr_pend_nxt;
   logic ext_pend_nxt;
   logic [7:0] ext_num_r;
   logic [7:0] ext_num_nxt;
   logic launch_nxt;
   logic [7:0] task_nxt;
   logic [IO_N-1:0] io_edge;

   // Both-edge capable inputs also launch on the falling edge
   assign io_edge = (io_irq_in & ~io_prev_r) | (~io_irq_in & io_prev_r & io_both_edge);

   always_comb begin
      io_pend_nxt = io_pend_r | io_edge;
      pwr_pend_nxt = pwr_pend_r | (power_fail & ~pwr_prev_r);
      sched_pend_nxt = sched_pend_r;
      for (int s = 0; s < SCHED_N; s++) begin
         sched_cnt_nxt[s] = sched_cnt_r[s];
         if (tick_r) begin
            sched_cnt_nxt[s] = sched_cnt_r[s] + 16'h0001;
            if (sched_cnt_r[s] == SCHED_LAST) begin
               sched_cnt_nxt[s] = 16'h0000;
               sched_pend_nxt[s] = 1'b1;
            end
         end
      end
      ext_pend_nxt = ext_busy_r;
      ext_num_nxt = ext_num_r;
      // A request while one waits is ignored; ext_busy_r tells the source
      if (ext_req && !ext_busy_r) begin
         ext_pend_nxt = 1'b1;
         ext_num_nxt = ext_task;
      end
      launch_nxt = 1'b0;
      task_nxt = task_num_r;
      // Grant clears the pending bit; a fresh power, periodic or I/O event of the same cycle is kept
      if (run_enable_r) begin
         if (pwr_pend_r) begin
            launch_nxt = 1'b1;
            task_nxt = TASK_POWER;
            pwr_pend_nxt = power_fail & ~pwr_prev_r;
         end else if (ext_busy_r) begin
            launch_nxt = 1'b1;
            task_nxt = ext_num_r;
            ext_pend_nxt = 1'b0;
         end else if (|sched_pend_r) begin
            launch_nxt = 1'b1;
            task_nxt = sched_pend_r[0] ? TASK_SCHED_BASE : TASK_SCHED_BASE + 8'h01;
            if (sched_pend_r[0]) begin
               sched_pend_nxt[0] = tick_r && (sched_cnt_r[0] == SCHED_LAST);
            end else begin
               sched_pend_nxt[1] = tick_r && (sched_cnt_r[1] == SCHED_LAST);
            end
         end else if (|io_pend_r) begin
            launch_nxt = 1'b1;
            for (int i = IO_N - 1; i >= 0; i--) begin
               if (io_pend_r[i]) begin
                  task_nxt = TASK_IO_BASE + 8'(i);
               end
            end
            io_pend_nxt = (io_pend_r & ~(io_pend_r & (~io_pend_r + 1'b1))) | io_edge;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         io_prev_r <= '0;
         io_pend_r <= '0;
         for (int s = 0; s < SCHED_N; s++) begin
            sched_cnt_r[s] <= 16'h0000;
         end
         sched_pend_r <= '0;
         pwr_prev_r <= 1'b0;
         pwr_pend_r <= 1'b0;
         ext_busy_r <= 1'b0;
         ext_num_r <= 8'h00;
         task_launch_r <= 1'b0;
         task_num_r <= 8'h00;
      end else begin
         io_prev_r <= io_irq_in;
         io_pend_r <= io_pend_nxt;
         sched_cnt_r <= sched_cnt_nxt;
         sched_pend_r <= sched_pend_nxt;
         pwr_prev_r <= power_fail;
         pwr_pend_r <= pwr_pend_nxt;
         ext_busy_r <= ext_pend_nxt;
         ext_num_r <= ext_num_nxt;
         task_launch_r <= launch_nxt;
         task_num_r <= task_nxt;
      end
   end
endmodule : ctwm_monitor

// ### verif/ctwm_checker_sva.sv
// Port checker for the cycle time watchdog monitor
`timescale 1ns/1ps
module ctwm_checker
   import ctwm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic parallel_mode,
   input wire logic prog_end,
   input wire logic cycle_end,
   input wire logic svc_end,
   input wire logic [15:0] aux_addr,
   input wire logic power_fail,
   input wire logic ext_req,
   input wire logic [15:0] aux_rdata_r,
   input wire logic [31:0] latest_cycle_r,
   input wire logic [31:0] peak_cycle_r,
   input wire logic [15:0] service_period_word_r,
   input wire logic cycle_overrun_flag_r,
   input wire logic service_overrun_flag_r,
   input wire logic run_enable_r,
   input wire logic ext_busy_r,
   input wire logic task_launch_r,
   input wire logic [7:0] task_num_r
);
   ////////////////////////////////////////
   // One clock domain, so one default clocking and disable
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Flags are sticky and must hold the block halted
   ovr_sticky_a: assert property (cycle_overrun_flag_r |=> cycle_overrun_flag_r)
      else $error("cycle overrun flag fell");
   svc_sticky_a: assert property (service_overrun_flag_r |=> service_overrun_flag_r)
      else $error("service overrun flag fell");
   halt_flags_a: assert property ((cycle_overrun_flag_r || service_overrun_flag_r) |-> !run_enable_r)
      else $error("running with a flag set");

   // Interrupt dispatch timing
   power_task_a: assert property (($rose(power_fail) && run_enable_r) |->
      ##[1:3] (task_launch_r && task_num_r == TASK_POWER))
      else $error("power task not launched");
   ext_busy_a: assert property ((ext_req && !ext_busy_r && run_enable_r) |=> ext_busy_r)
      else $error("external request not taken");
   ext_launch_a: assert property ($fell(ext_busy_r) |-> task_launch_r)
      else $error("external request lost");

   // Records move only at their close strobes; peak never below latest; latest low word reads back
   peak_ge_a: assert property (peak_cycle_r >= latest_cycle_r)
      else $error("peak below latest");
   latest_cause_a: assert property (!$stable(latest_cycle_r) |-> ($past(prog_end) || $past(cycle_end)))
      else $error("latest changed without close");
   svc_word_a: assert property (!$stable(service_period_word_r) |->
      ($past(svc_end) && $past(parallel_mode)))
      else $error("service word changed unexpectedly");
   aux_latest_a: assert property ((aux_addr == ADDR_LATEST_LOW) |=>
      (aux_rdata_r == 16'($past(latest_cycle_r))))
      else $error("latest low word read wrong");
endmodule : ctwm_checker

bind ctwm_monitor ctwm_checker u_chk (
   .ref_clk(ref_clk), .resetn(resetn), .parallel_mode(parallel_mode),
   .prog_end(prog_end), .cycle_end(cycle_end), .svc_end(svc_end), .aux_addr(aux_addr),
   .power_fail(power_fail), .ext_req(ext_req), .aux_rdata_r(aux_rdata_r),
   .latest_cycle_r(latest_cycle_r), .peak_cycle_r(peak_cycle_r),
   .service_period_word_r(service_period_word_r),
   .cycle_overrun_flag_r(cycle_overrun_flag_r),
   .service_overrun_flag_r(service_overrun_flag_r), .run_enable_r(run_enable_r),
   .ext_busy_r(ext_busy_r), .task_launch_r(task_launch_r), .task_num_r(task_num_r)
);

// ### verif/cycle_time_watchdog_monitor_tb_top.sv
// Self-checking bench for the cycle time watchdog monitor
`timescale 1ns/1ps
module cycle_time_watchdog_monitor_tb_top;
   import ctwm_pkg::*;
   localparam int TCK = 2;
   logic ref_clk, resetn, parallel_mode, cycle_start, prog_end, cycle_end;
   logic svc_start, svc_end, aux_wr, power_fail, ext_req;
   logic [15:0] aux_addr, aux_wdata, aux_rdata_r, service_period_word_r;
   logic [31:0] io_irq_in, io_both_edge, latest_cycle_r, peak_cycle_r, avg_cycle_r;
   logic [7:0] ext_task, task_num_r;
   logic cycle_overrun_flag_r, service_overrun_flag_r, run_enable_r, ext_busy_r;
   logic task_launch_r;
   int n_errors = 0, samples_checked = 0, cyc = 0, seed = 32'h2FDE, hp = 0;
   int launch_cnt [256];
   logic [31:0] hist [8] = '{default: 32'h0};
   logic [31:0] peak_m = 32'h0;
   logic [15:0] svc_m = 16'h0;
   logic [15:0] lo, hi;

   ////////////////////////////////////////
   // Two-clock tick makes the 2 s servicing limit reachable in a short run
   ctwm_monitor #(.SCHED_TICKS(2), .TICK_DIV(TCK)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .parallel_mode(parallel_mode),
      .cycle_start(cycle_start), .prog_end(prog_end), .cycle_end(cycle_end),
      .svc_start(svc_start), .svc_end(svc_end), .aux_wr(aux_wr), .aux_addr(aux_addr),
      .aux_wdata(aux_wdata), .io_irq_in(io_irq_in), .io_both_edge(io_both_edge),
      .power_fail(power_fail), .ext_req(ext_req), .ext_task(ext_task),
      .aux_rdata_r(aux_rdata_r), .latest_cycle_r(latest_cycle_r),
      .peak_cycle_r(peak_cycle_r), .avg_cycle_r(avg_cycle_r),
      .service_period_word_r(service_period_word_r),
      .cycle_overrun_flag_r(cycle_overrun_flag_r),
      .service_overrun_flag_r(service_overrun_flag_r), .run_enable_r(run_enable_r),
      .ext_busy_r(ext_busy_r), .task_launch_r(task_launch_r), .task_num_r(task_num_r)
   );

   // Clock at 50 ns
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Launch tally per task, plus hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (task_launch_r === 1'b1)
         launch_cnt[task_num_r]++;
      if (cyc == 50000) begin
         n_errors++;
         give_verdict();
      end
   end

   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wait_n

   // Extra idle edge so a following pulse never re-raises in the same step
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
      @(negedge ref_clk);
   endtask : pulse

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      aux_addr = a;
      @(negedge ref_clk);
      d = aux_rdata_r;
   endtask : rd

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      aux_addr = a;
      aux_wdata = d;
      pulse(aux_wr);
   endtask : wr

   function automatic logic [31:0] avg_exp();
      logic [34:0] s;
      s = '0;
      for (int i = 0; i < 8; i++)
         s += 35'(hist[i]);
      return 32'(s >> 3);
   endfunction : avg_exp

   // Even-length steps keep every start off a tick edge, so counts are exact
   task automatic run_cycle(input int k, input logic par);
      parallel_mode = par;
      pulse(cycle_start);
      wait_n(TCK * k - 2);
      if (par) begin
         pulse(prog_end);
         wait_n(TCK);
      end
      pulse(cycle_end);
      hist[hp] = 32'(k);
      hp = (hp + 1) % 8;
      if (32'(k) > peak_m)
         peak_m = 32'(k);
      check(latest_cycle_r, 32'(k));
      check(peak_cycle_r, peak_m);
      check(avg_cycle_r, avg_exp());
      rd(ADDR_PEAK_LOW, lo);
      rd(ADDR_PEAK_HIGH, hi);
      check({hi, lo}, peak_m);
   endtask : run_cycle

   task automatic run_svc(input int k, input logic par);
      parallel_mode = par;
      pulse(svc_start);
      wait_n(TCK * k - 2);
      pulse(svc_end);
      if (par)
         svc_m = 16'(k);
      check(service_period_word_r, svc_m);
   endtask : run_svc

   ////////////////////////////////////////
   // Main sequence
   initial begin
      int c2, c3;
      logic [7:0] t;
      {resetn, parallel_mode, cycle_start, prog_end, cycle_end} = 5'h00;
      {svc_start, svc_end, aux_wr, power_fail, ext_req} = 5'h00;
      aux_addr = 16'h0000;
      aux_wdata = 16'h0000;
      io_irq_in = 32'h0;
      io_both_edge = 32'h0;
      ext_task = 8'h00;
      wait_n(10);
      resetn = 1'b1;
      wait_n(3);
      check(run_enable_r, 32'h1);
      rd(ADDR_WATCH_SETUP, lo);
      check(lo, SETUP_RESET);
      wr(ADDR_WATCH_SETUP, 16'h8FA0);
      wr(ADDR_LATEST_LOW, 16'hA5A5);
      rd(ADDR_WATCH_SETUP, lo);
      check(lo, 16'h8FA0);
      rd(ADDR_LATEST_LOW, lo);
      check(lo, 16'h0000);
      rd(16'h0200, lo);
      check(lo, 16'h0000);
      // Falling then rising values exercise the peak hold
      run_cycle(3, 1'b0);
      run_cycle(1, 1'b1);
      run_cycle(2, 1'b0);
      for (int i = 0; i < 6; i++)
         run_cycle(1 + int'($random(seed) & 1), 1'($random(seed)));
      run_svc(2, 1'b1);
      run_svc(1, 1'b0);
      // Both periodic tasks, 10 ticks at a 2-tick period
      c2 = launch_cnt[2];
      c3 = launch_cnt[3];
      wait_n(TCK * 10);
      check(launch_cnt[2] - c2, 5);
      check(launch_cnt[3] - c3, 5);
      io_both_edge = $random(seed);
      for (int i = 0; i < 32; i++) begin
         c2 = launch_cnt[100 + i];
         io_irq_in[i] = 1'b1;
         wait_n(6);
         check(launch_cnt[100 + i] - c2, 1);
         io_irq_in[i] = 1'b0;
         wait_n(6);
         check(launch_cnt[100 + i] - c2, 1 + io_both_edge[i]);
      end
      c2 = launch_cnt[1];
      power_fail = 1'b1;
      wait_n(6);
      power_fail = 1'b0;
      wait_n(6);
      check(launch_cnt[1] - c2, 1);
      // Second request while busy must be dropped
      for (int i = 0; i < 4; i++) begin
         t = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(4 + ($random(seed) & 32'h3F));
         c2 = launch_cnt[t];
         c3 = launch_cnt[t ^ 8'h80];
         ext_task = t;
         ext_req = 1'b1;
         @(negedge ref_clk);
         ext_task = t ^ 8'h80;
         @(negedge ref_clk);
         ext_req = 1'b0;
         wait_n(6);
         check(launch_cnt[t] - c2, 1);
         check(launch_cnt[t ^ 8'h80] - c3, 0);
      end
      // Shortest limit, 100 ticks: equal to it passes, one tick more halts
      wr(ADDR_WATCH_SETUP, 16'h8001);
      pulse(cycle_start);
      wait_n(TCK * 100 - 2);
      check(cycle_overrun_flag_r, 32'h0);
      wait_n(3);
      check(cycle_overrun_flag_r, 32'h1);
      check(run_enable_r, 32'h0);
      pulse(cycle_end);
      check(latest_cycle_r, hist[(hp + 7) % 8]);
      c2 = launch_cnt[1];
      pulse(power_fail);
      wait_n(5);
      check(launch_cnt[1] - c2, 0);
      // Servicing limit is still watched while halted
      pulse(svc_start);
      wait_n(TCK * 20000 - 2);
      check(service_overrun_flag_r, 32'h0);
      wait_n(3);
      check(service_overrun_flag_r, 32'h1);
      check(run_enable_r, 32'h0);
      give_verdict();
   end
endmodule : cycle_time_watchdog_monitor_tb_top
